// [scc_pkg.sv]
// constants, code tables and coding functions for the special-character codec
// assumes symbols are abcdei_fghj with bit a in bit 9; rd value 1 means positive
package scc_pkg;

   // host special-character codes (hgf_edcba)
   localparam logic [7:0] C_EOF = 8'h22;
   localparam logic [7:0] C_CV = 8'hE0;
   localparam logic [7:0] C_NEGK = 8'hE1;
   localparam logic [7:0] C_POSK = 8'hE2;
   localparam logic [7:0] C_RDV = 8'hE4;
   localparam logic [7:0] C_K285 = 8'h05;
   localparam logic [4:0] C_Y0_HI = 5'h00;
   localparam logic [7:0] K285_CHR = 8'hBC;
   localparam logic [4:0] K28_X = 5'h1C;

   // fixed line symbols
   localparam logic [9:0] K285_RDN = 10'h0FA;
   localparam logic [9:0] K285_RDP = 10'h305;
   localparam logic [9:0] VIOL_RDN = 10'h375;
   localparam logic [9:0] VIOL_RDP = 10'h08A;
   localparam logic [5:0] K28_6B_RDN = 6'h0F;
   localparam logic [5:0] K28_6B_RDP = 6'h30;
   localparam logic [5:0] D7_6B_RDN = 6'h38;
   localparam logic [5:0] D7_6B_RDP = 6'h07;
   localparam logic [3:0] X3_4B_RDN = 4'hC;
   localparam logic [3:0] ALT7_4B = 4'h7;
   localparam int BAL6 = 3;
   localparam int BAL4 = 2;
   localparam int N_X = 32;
   localparam int N_Y = 8;

   // negative-disparity forms
   localparam logic [5:0] T6 [N_X] = '{6'h27, 6'h1D, 6'h2D, 6'h31, 6'h35, 6'h29, 6'h19, 6'h38,
      6'h39, 6'h25, 6'h15, 6'h34, 6'h0D, 6'h2C, 6'h1C, 6'h17, 6'h1B, 6'h23, 6'h13, 6'h32,
      6'h0B, 6'h2A, 6'h1A, 6'h3A, 6'h33, 6'h26, 6'h16, 6'h36, 6'h0E, 6'h2E, 6'h1E, 6'h2B};
   localparam logic [3:0] T4 [N_Y] = '{4'hB, 4'h9, 4'h5, 4'hC, 4'hD, 4'hA, 4'h6, 4'hE};

   function automatic logic [5:0] enc6(input logic [4:0] x, input logic rd);
      logic [5:0] t;
      t = T6[x];
      return (rd && ($countones(t) != BAL6 || t == D7_6B_RDN)) ? ~t : t;
   endfunction : enc6

   function automatic logic [3:0] enc4(input logic [2:0] y, input logic rd, input logic alt);
      logic [3:0] t;
      t = (y == 3'h7 && alt) ? ALT7_4B : T4[y];
      return (rd && ($countones(t) != BAL4 || t == X3_4B_RDN)) ? ~t : t;
   endfunction : enc4

   // K28 tails: biased forms invert on negative entry, balanced ones on positive entry
   function automatic logic [3:0] k28_4b(input logic [2:0] y, input logic rd);
      logic [3:0] t;
      logic biased;
      t = (y == 3'h7) ? ALT7_4B : T4[y];
      biased = ($countones(t) != BAL4) || (t == X3_4B_RDN);
      return (biased != rd) ? ~t : t;
   endfunction : k28_4b

   // alternate x.7 avoids a run of five equal bits
   function automatic logic need_alt(input logic [4:0] x, input logic rdm);
      if (rdm)
         return (x == 5'h0B || x == 5'h0D || x == 5'h0E);
      return (x == 5'h11 || x == 5'h12 || x == 5'h14);
   endfunction : need_alt

   function automatic logic mid_rd(input logic [5:0] s6, input logic rd);
      return ($countones(s6) != BAL6) ? ($countones(s6) > BAL6) : rd;
   endfunction : mid_rd

   // disparity at the end of a whole symbol
   function automatic logic rd_after(input logic [9:0] sym, input logic rd);
      logic r;
      r = mid_rd(sym[9:4], rd);
      return ($countones(sym[3:0]) != BAL4) ? ($countones(sym[3:0]) > BAL4) : r;
   endfunction : rd_after

endpackage : scc_pkg

// [scc_cw_if.sv]
// bundle between the codec and its table encoder or table decoder
// assumes one instance per direction, all combinational
`timescale 1ns/100ps
interface scc_cw_if;
   logic [7:0] chr;
   logic k;
   logic alt;
   logic rd;
   logic [9:0] sym;
   logic ok;
   logic rd_err;
   modport enc_mp (input chr, input k, input alt, input rd, output sym);
   modport dec_mp (input sym, input rd, output chr, output k, output ok, output rd_err);
endinterface : scc_cw_if

// [scc_enc.sv]
// table encoder: one character plus entry disparity to one 10-bit symbol
// assumes the caller keeps the running disparity
`timescale 1ns/100ps
module scc_enc
   import scc_pkg::*;
(
   scc_cw_if.enc_mp cw
);
   logic [4:0] x;
   logic [2:0] y;
   logic [5:0] s6;
   logic rdm;
   logic [3:0] f4;

   // k flag with x other than 28 forces the alternate tail
   always_comb begin
      x = cw.chr[4:0];
      y = cw.chr[7:5];
      if (cw.k && x == K28_X)
         s6 = cw.rd ? K28_6B_RDP : K28_6B_RDN;
      else
         s6 = enc6(x, cw.rd);
      rdm = mid_rd(s6, cw.rd);
      if (cw.k && x == K28_X)
         f4 = k28_4b(y, cw.rd);
      else
         f4 = enc4(y, rdm, cw.alt || cw.k || need_alt(x, rdm));
      cw.sym = {s6, f4};
   end
endmodule : scc_enc

// [scc_dec.sv]
// table decoder: searches both disparity columns for each sub-block except the K28 tail
// assumes the caller supplies the running disparity at symbol entry
`timescale 1ns/100ps
module scc_dec
   import scc_pkg::*;
(
   scc_cw_if.dec_mp cw
);
   logic [5:0] s6;
   logic [3:0] f4;
   logic [4:0] x;
   logic [2:0] y;
   logic hit6;
   logic hit4;
   logic k28;
   logic rdm;

   // search by regenerating every code; small tables keep this cheap
   always_comb begin
      s6 = cw.sym[9:4];
      f4 = cw.sym[3:0];
      x = 5'h00;
      y = 3'h0;
      hit6 = 1'b0;
      hit4 = 1'b0;
      k28 = (s6 == K28_6B_RDN || s6 == K28_6B_RDP);
      if (k28) begin
         hit6 = 1'b1;
         x = K28_X;
      end
      for (int i = 0; i < N_X; i++) begin
         if (s6 == enc6(5'(i), 1'b0) || s6 == enc6(5'(i), 1'b1)) begin
            hit6 = 1'b1;
            x = 5'(i);
         end
      end
      rdm = mid_rd(s6, cw.rd);
      for (int j = 0; j < N_Y; j++) begin
         // the K28 head fixes the entry disparity; the two tail columns overlap
         if (k28 && f4 == k28_4b(3'(j), s6 == K28_6B_RDP)) begin
            hit4 = 1'b1;
            y = 3'(j);
         end
         if (!k28 && (f4 == enc4(3'(j), 1'b0, 1'b0) || f4 == enc4(3'(j), 1'b1, 1'b0) ||
               f4 == enc4(3'(j), 1'b0, 1'b1) || f4 == enc4(3'(j), 1'b1, 1'b1))) begin
            hit4 = 1'b1;
            y = 3'(j);
         end
      end
      cw.chr = {y, x};
      cw.k = k28;
      cw.ok = hit6 && hit4;
      // each unbalanced or biased sub-block must match its entry disparity
      cw.rd_err = ($countones(s6) > BAL6 && cw.rd) || ($countones(s6) < BAL6 && !cw.rd) ||
         (s6 == D7_6B_RDN && cw.rd) || (s6 == D7_6B_RDP && !cw.rd) ||
         ($countones(f4) > BAL4 && rdm) || ($countones(f4) < BAL4 && !rdm) ||
         (f4 == X3_4B_RDN && rdm) || (f4 == ~X3_4B_RDN && !rdm);
   end
endmodule : scc_dec

// [scc_codec.sv]
// one channel of special-character 8b/10b coding, transmit and receive
// assumes the host and the deserializer share mclk_in; framer enable is a pin
//
// Function
// - C2.1 sends K28.5 in the form set by running disparity and marks the next data character.
// - after C2.1 the next data character's lsb becomes 0 when disparity there is positive.
// - after C2.1 the next data character's lsb becomes 1 when disparity there is negative.
// - C1.7 always sends the negative-entry form of K28.5.
// - a negative-entry K28.5 received at positive disparity decodes as C1.7.
// - C2.7 always sends the positive-entry form of K28.5.
// - a positive-entry K28.5 received at negative disparity decodes as C2.7.
// - a K28.5 whose disparity agrees decodes as C5.0.
// - C4.7 sends a deliberate disparity-violation pattern.
// - C4.7 is decoded only for a table symbol whose disparity disagrees.
// - K28.5 marks framing on receive and fills idle slots on transmit.
`timescale 1ns/100ps
module scc_codec
   import scc_pkg::*;
(
   input wire logic mclk_in,
   input wire logic rst_in,
   input wire logic tx_valid_in,
   input wire logic tx_special_in,
   input wire logic [7:0] tx_char_in,
   output logic [9:0] tx_sym_out,
   output logic tx_rd_out,
   input wire logic rx_valid_in,
   input wire logic [9:0] rx_sym_in,
   input wire logic rx_framer_enable_in,
   output logic [7:0] rx_char_out,
   output logic rx_special_out,
   output logic rx_valid_out,
   output logic rx_comma_out,
   output logic rx_rd_out
);

   typedef enum logic [1:0] {
      TS_ENC = 2'b00,
      TS_NEGK = 2'b01,
      TS_POSK = 2'b10,
      TS_RDV = 2'b11
   } scc_txsel_t;

   scc_txsel_t tx_sel;
   logic [9:0] tx_sym_reg;
   logic [9:0] tx_sym_next;
   logic tx_rd_reg;
   logic eof_pend_reg;
   logic eof_set;
   logic [2:0] fe_sync_reg;
   logic fe_reg;
   logic rx_rd_reg;
   logic [7:0] rx_char_reg;
   logic [7:0] rx_char_next;
   logic rx_spec_reg;
   logic rx_spec_next;
   logic rx_valid_reg;
   logic rx_comma_reg;
   logic is_k285;

   scc_cw_if ecw ();
   scc_cw_if dcw ();

   scc_enc u_enc (
      .cw(ecw)
   );

   scc_dec u_dec (
      .cw(dcw)
   );

   ////////////////////////////////////////////////////////////////////////////
   // framer enable pin: three stages, a change counts once the last two agree
   always_ff @(posedge mclk_in or posedge rst_in) begin
      if (rst_in) begin
         fe_sync_reg <= 3'h0;
      end else begin
         fe_sync_reg <= {fe_sync_reg[1:0], rx_framer_enable_in};
      end
   end

   always_ff @(posedge mclk_in or posedge rst_in) begin
      if (rst_in) begin
         fe_reg <= 1'b0;
      end else if (fe_sync_reg[1] == fe_sync_reg[2]) begin
         fe_reg <= fe_sync_reg[2];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // transmit selection; reserved codes fall back to fill rather than garbage
   always_comb begin
      tx_sel = TS_ENC;
      ecw.chr = tx_char_in;
      ecw.k = 1'b0;
      ecw.alt = 1'b0;
      ecw.rd = tx_rd_reg;
      eof_set = 1'b0;
      if (!tx_valid_in) begin
         ecw.chr = K285_CHR;
         ecw.k = 1'b1;
      end else if (tx_special_in) begin
         if (tx_char_in[7:3] == C_Y0_HI) begin
            ecw.chr = {tx_char_in[2:0], K28_X};
            ecw.k = 1'b1;
         end else if (tx_char_in == C_EOF) begin
            ecw.chr = K285_CHR;
            ecw.k = 1'b1;
            eof_set = 1'b1;
         end else if (tx_char_in == C_CV) begin
            ecw.alt = 1'b1;
         end else if (tx_char_in == C_NEGK) begin
            tx_sel = TS_NEGK;
         end else if (tx_char_in == C_POSK) begin
            tx_sel = TS_POSK;
         end else if (tx_char_in == C_RDV) begin
            tx_sel = TS_RDV;
         end else begin
            ecw.chr = K285_CHR;
            ecw.k = 1'b1;
         end
      end else if (eof_pend_reg) begin
         ecw.chr = {tx_char_in[7:1], ~tx_rd_reg};
      end
   end

   // final line symbol
   always_comb begin
      unique case (tx_sel)
         TS_ENC: tx_sym_next = ecw.sym;
         TS_NEGK: tx_sym_next = K285_RDN;
         TS_POSK: tx_sym_next = K285_RDP;
         TS_RDV: tx_sym_next = tx_rd_reg ? VIOL_RDP : VIOL_RDN;
      endcase
   end

   // symbol and disparity, one character per clock
   always_ff @(posedge mclk_in or posedge rst_in) begin
      if (rst_in) begin
         tx_sym_reg <= K285_RDN;
         tx_rd_reg <= 1'b0;
      end else begin
         tx_sym_reg <= tx_sym_next;
         tx_rd_reg <= rd_after(tx_sym_next, tx_rd_reg);
      end
   end

   // mark waits for the next host data character; a new C2.1 re-arms it
   always_ff @(posedge mclk_in or posedge rst_in) begin
      if (rst_in) begin
         eof_pend_reg <= 1'b0;
      end else if (eof_set) begin
         eof_pend_reg <= 1'b1;
      end else if (tx_valid_in && !tx_special_in) begin
         eof_pend_reg <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // receive classification; invalid symbols report the code violation code
   assign dcw.sym = rx_sym_in;
   assign dcw.rd = rx_rd_reg;
   assign is_k285 = (rx_sym_in == K285_RDN) || (rx_sym_in == K285_RDP);

   always_comb begin
      rx_char_next = dcw.chr;
      rx_spec_next = dcw.k;
      if (!dcw.ok) begin
         rx_char_next = C_CV;
         rx_spec_next = 1'b1;
      end else if (is_k285) begin
         rx_spec_next = 1'b1;
         if (rx_sym_in == K285_RDN && rx_rd_reg)
            rx_char_next = C_NEGK;
         else if (rx_sym_in == K285_RDP && !rx_rd_reg)
            rx_char_next = C_POSK;
         else
            rx_char_next = C_K285;
      end else if (dcw.rd_err) begin
         rx_char_next = C_RDV;
         rx_spec_next = 1'b1;
      end else if (dcw.k) begin
         rx_char_next = {C_Y0_HI, dcw.chr[7:5]};
      end
   end

   // decoded character and receive disparity, held between valid symbols
   always_ff @(posedge mclk_in or posedge rst_in) begin
      if (rst_in) begin
         rx_char_reg <= 8'h00;
         rx_spec_reg <= 1'b0;
         rx_rd_reg <= 1'b0;
      end else if (rx_valid_in) begin
         rx_char_reg <= rx_char_next;
         rx_spec_reg <= rx_spec_next;
         rx_rd_reg <= rd_after(rx_sym_in, rx_rd_reg);
      end
   end

   // strobes; comma only while framing is enabled
   always_ff @(posedge mclk_in or posedge rst_in) begin
      if (rst_in) begin
         rx_valid_reg <= 1'b0;
         rx_comma_reg <= 1'b0;
      end else begin
         rx_valid_reg <= rx_valid_in;
         rx_comma_reg <= rx_valid_in && fe_reg && is_k285;
      end
   end

   assign tx_sym_out = tx_sym_reg;
   assign tx_rd_out = tx_rd_reg;
   assign rx_char_out = rx_char_reg;
   assign rx_special_out = rx_spec_reg;
   assign rx_valid_out = rx_valid_reg;
   assign rx_comma_out = rx_comma_reg;
   assign rx_rd_out = rx_rd_reg;

   ////////////////////////////////////////////////////////////////////////////
   // checks
   eof_k285_a: assert property (
      @(posedge mclk_in) disable iff (rst_in)
      tx_valid_in && tx_special_in && tx_char_in == C_EOF
      |=> tx_sym_out == ($past(tx_rd_out) ? K285_RDP : K285_RDN))
      else $error("eof did not send k28.5 of current disparity");

   eof_lsb_low_a: assert property (
      @(posedge mclk_in) disable iff (rst_in)
      eof_pend_reg && tx_valid_in && !tx_special_in && tx_rd_out |-> ecw.chr[0] == 1'b0)
      else $error("eof follower lsb not cleared at positive disparity");

   eof_lsb_high_a: assert property (
      @(posedge mclk_in) disable iff (rst_in)
      eof_pend_reg && tx_valid_in && !tx_special_in && !tx_rd_out |-> ecw.chr[0] == 1'b1)
      else $error("eof follower lsb not set at negative disparity");

   neg_k285_tx_a: assert property (
      @(posedge mclk_in) disable iff (rst_in)
      tx_valid_in && tx_special_in && tx_char_in == C_NEGK |=> tx_sym_out == K285_RDN ##0 tx_rd_out)
      else $error("forced negative k28.5 wrong");

   pos_k285_tx_a: assert property (
      @(posedge mclk_in) disable iff (rst_in)
      tx_valid_in && tx_special_in && tx_char_in == C_POSK |=> tx_sym_out == K285_RDP ##0 !tx_rd_out)
      else $error("forced positive k28.5 wrong");

   viol_pattern_a: assert property (
      @(posedge mclk_in) disable iff (rst_in)
      tx_valid_in && tx_special_in && tx_char_in == C_RDV
      |=> tx_sym_out == ($past(tx_rd_out) ? VIOL_RDP : VIOL_RDN))
      else $error("violation pattern wrong");

   idle_fill_a: assert property (
      @(posedge mclk_in) disable iff (rst_in)
      !rst_in && !tx_valid_in |=> (tx_sym_out == K285_RDN || tx_sym_out == K285_RDP) ##0
      tx_rd_out != $past(tx_rd_out))
      else $error("idle slot not filled with k28.5");

   tx_rd_track_a: assert property (
      @(posedge mclk_in) disable iff (rst_in)
      !$past(rst_in) |-> tx_rd_out == rd_after(tx_sym_out, $past(tx_rd_out)))
      else $error("transmit disparity out of step");

   eof_hold_a: assert property (
      @(posedge mclk_in) disable iff (rst_in)
      eof_pend_reg && !tx_valid_in |=> eof_pend_reg)
      else $error("end-of-frame mark lost on a fill slot");

   rx_neg_k_a: assert property (
      @(posedge mclk_in) disable iff (rst_in)
      rx_valid_in && rx_sym_in == K285_RDN && rx_rd_out
      |=> rx_valid_out && rx_special_out && rx_char_out == C_NEGK)
      else $error("wrong-disparity negative k28.5 not reported");

   rx_pos_k_a: assert property (
      @(posedge mclk_in) disable iff (rst_in)
      rx_valid_in && rx_sym_in == K285_RDP && !rx_rd_out
      |=> rx_valid_out && rx_special_out && rx_char_out == C_POSK)
      else $error("wrong-disparity positive k28.5 not reported");

   rx_good_k_a: assert property (
      @(posedge mclk_in) disable iff (rst_in)
      rx_valid_in && ((rx_sym_in == K285_RDN && !rx_rd_out) ||
      (rx_sym_in == K285_RDP && rx_rd_out)) |=> rx_special_out && rx_char_out == C_K285)
      else $error("matching k28.5 not reported as c5.0");

   rx_rd_viol_a: assert property (
      @(posedge mclk_in) disable iff (rst_in)
      rx_valid_in && dcw.ok && dcw.rd_err && !is_k285
      |=> rx_valid_out && rx_special_out && rx_char_out == C_RDV)
      else $error("disparity violation not reported");

   rx_rdv_only_a: assert property (
      @(posedge mclk_in) disable iff (rst_in)
      rx_valid_in && !(dcw.ok && dcw.rd_err)
      |=> !(rx_special_out && rx_char_out == C_RDV))
      else $error("disparity violation reported without cause");

   comma_sync_a: assert property (
      @(posedge mclk_in) disable iff (rst_in)
      rx_comma_out |-> rx_valid_out && rx_special_out &&
      (rx_char_out == C_K285 || rx_char_out == C_NEGK || rx_char_out == C_POSK))
      else $error("comma reported for a non-sync symbol");

endmodule : scc_codec

// [scc_host.sv]
// host controller model: hands the codec one transmit character per clock
// assumes the bench calls put just after each rising edge of the character clock
`timescale 1ns/100ps
module scc_host
   import scc_pkg::*;
(
   input wire logic framer_on_in,
   output logic tx_valid_out,
   output logic tx_special_out,
   output logic [7:0] tx_char_out
);
   int alias_cnt = 0;
   logic [7:0] prev_code = 8'h00;
   logic prev_special = 1'b0;

   // quiet lines at time zero
   initial begin
      tx_valid_out = 1'b0;
      tx_special_out = 1'b0;
      tx_char_out = 8'h00;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // one character per call; idle slots flip the data lines so stale values never pass
   task automatic put(input logic valid, input logic special, input logic [7:0] code);
      // pairs that fake a sync character are counted; none should occur while framing
      if (framer_on_in && valid && !special && prev_special) begin
         if ((prev_code == 8'h07 && (code[4:0] == 5'h0B || code[4:0] == 5'h14)) ||
               (prev_code == C_CV && code[4:0] == 5'h0B)) begin
            alias_cnt++;
         end
      end
      prev_code = code;
      prev_special = valid && special;
      tx_valid_out <= valid;
      tx_special_out <= valid ? special : ~tx_special_out;
      tx_char_out <= valid ? code : ~tx_char_out;
   endtask : put
endmodule : scc_host

// [scc_tb.sv]
// self-checking bench for the special-character codec
// assumes the host model drives transmit pins and the bench drives the receive symbol
`timescale 1ns/100ps
module tb
   import scc_pkg::*;
();
   logic mclk_in, rst_in, rx_valid_in, rx_framer_enable_in;
   logic tx_valid_in, tx_special_in, tx_rd_out, rx_special_out, rx_valid_out;
   logic rx_comma_out, rx_rd_out;
   logic [7:0] tx_char_in, rx_char_out;
   logic [9:0] tx_sym_out, rx_sym_in;
   int failures = 0;
   int num_checks = 0;
   // expectation of the step in flight, judged one clock later
   logic p_on, p_rd, p_rv, p_sp, p_rrd, p_cm, trd, l_sp, l_rrd;
   logic [9:0] p_sym;
   logic [7:0] p_ch, l_ch;

   scc_codec u_dut (.mclk_in(mclk_in), .rst_in(rst_in), .tx_valid_in(tx_valid_in),
      .tx_special_in(tx_special_in), .tx_char_in(tx_char_in), .tx_sym_out(tx_sym_out),
      .tx_rd_out(tx_rd_out), .rx_valid_in(rx_valid_in), .rx_sym_in(rx_sym_in),
      .rx_framer_enable_in(rx_framer_enable_in), .rx_char_out(rx_char_out),
      .rx_special_out(rx_special_out), .rx_valid_out(rx_valid_out),
      .rx_comma_out(rx_comma_out), .rx_rd_out(rx_rd_out));
   scc_host u_host (.framer_on_in(rx_framer_enable_in), .tx_valid_out(tx_valid_in),
      .tx_special_out(tx_special_in), .tx_char_out(tx_char_in));

   ////////////////////////////////////////////////////////////////////////////////
   // compare, count and report
   task automatic check(input logic [9:0] seen, input logic [9:0] exp, input string what);
      num_checks++;
      if (seen !== exp) begin
         failures++;
         $display("[ERR] %0t %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask : check

   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : report_and_stop

   task automatic judge();
      check(tx_sym_out, p_sym, "tx symbol");
      check({9'h000, tx_rd_out}, {9'h000, p_rd}, "tx disparity");
      check({9'h000, rx_valid_out}, {9'h000, p_rv}, "rx valid");
      check({2'h0, rx_char_out}, {2'h0, p_ch}, "rx char");
      check({9'h000, rx_special_out}, {9'h000, p_sp}, "rx special");
      check({9'h000, rx_rd_out}, {9'h000, p_rrd}, "rx disparity");
      check({9'h000, rx_comma_out}, {9'h000, p_cm}, "rx comma");
   endtask : judge

   ////////////////////////////////////////////////////////////////////////////////
   // one clock of traffic: drive now, judge the previous clock at the falling edge
   task automatic step(input logic tv, input logic ts, input logic [7:0] tc,
         input logic [9:0] esym, input logic erd, input logic rv, input logic [9:0] rs,
         input logic [7:0] ech, input logic esp, input logic errd, input logic ecm);
      u_host.put(tv, ts, tc);
      rx_valid_in <= rv;
      rx_sym_in <= rv ? rs : ~rx_sym_in;
      @(negedge mclk_in);
      if (p_on)
         judge();
      {p_on, p_sym, p_rd, p_rv, p_ch, p_sp, p_rrd, p_cm} = {1'b1, esym, erd, rv, ech, esp,
         errd, ecm};
      trd = erd;
      {l_ch, l_sp, l_rrd} = {ech, esp, errd};
      @(posedge mclk_in);
   endtask : step

   // fill slot on transmit, receive side idle and holding
   task automatic idle();
      step(1'b0, 1'b0, 8'h00, trd ? K285_RDP : K285_RDN, ~trd, 1'b0, 10'h000, l_ch, l_sp,
         l_rrd, 1'b0);
   endtask : idle

   task automatic txs(input logic ts, input logic [7:0] tc, input logic [9:0] esym,
         input logic erd);
      step(1'b1, ts, tc, esym, erd, 1'b0, 10'h000, l_ch, l_sp, l_rrd, 1'b0);
   endtask : txs

   // comma expected for either sync form while framing is on
   task automatic rxs(input logic [9:0] rs, input logic [7:0] ech, input logic esp,
         input logic errd);
      step(1'b0, 1'b0, 8'h00, trd ? K285_RDP : K285_RDN, ~trd, 1'b1, rs, ech, esp, errd,
         rx_framer_enable_in && (rs == K285_RDN || rs == K285_RDP));
   endtask : rxs

   ////////////////////////////////////////////////////////////////////////////////
   // scenarios
   task automatic t_reset();
      check(tx_sym_out, K285_RDN, "reset symbol");
      check({9'h000, tx_rd_out}, 10'h000, "reset tx rd");
      check({rx_char_out, rx_valid_out, rx_rd_out}, 10'h000, "reset rx");
   endtask : t_reset

   // idle slots alternate sync forms as disparity flips
   task automatic t_fill();
      idle();
      idle();
   endtask : t_fill

   // forced polarity at both entry disparities
   task automatic t_forced();
      txs(1'b1, C_NEGK, K285_RDN, 1'b1);
      txs(1'b1, C_NEGK, K285_RDN, 1'b1);
      txs(1'b1, C_POSK, K285_RDP, 1'b0);
      txs(1'b1, C_POSK, K285_RDP, 1'b0);
      txs(1'b1, 8'h07, 10'h0F8, 1'b0);
      txs(1'b1, C_CV, 10'h278, 1'b0);
   endtask : t_forced

   task automatic t_viol();
      txs(1'b1, C_RDV, VIOL_RDN, 1'b1);
      txs(1'b1, C_RDV, VIOL_RDP, 1'b0);
   endtask : t_viol

   // end-of-frame mark, also carried across a fill and a forced sync
   task automatic t_eof();
      txs(1'b1, C_EOF, K285_RDN, 1'b1);
      txs(1'b0, 8'hB5, 10'h0BA, 1'b1);
      txs(1'b1, C_EOF, K285_RDP, 1'b0);
      idle();
      txs(1'b1, C_POSK, K285_RDP, 1'b0);
      txs(1'b0, 8'hB4, 10'h2AA, 1'b0);
      txs(1'b0, 8'hB4, 10'h0BA, 1'b0);
   endtask : t_eof

   // decode sync forms at both disparities and both forms of a data character at negative disparity, back to back
   task automatic t_rx();
      rxs(K285_RDN, C_K285, 1'b1, 1'b1);
      rxs(K285_RDN, C_NEGK, 1'b1, 1'b1);
      rxs(K285_RDP, C_K285, 1'b1, 1'b0);
      rxs(K285_RDP, C_POSK, 1'b1, 1'b0);
      rxs(10'h229, C_RDV, 1'b1, 1'b0);
      rxs(10'h1D9, 8'h21, 1'b0, 1'b1);
      idle();
   endtask : t_rx

   // comma reporting follows the framer pin after its settling edges
   task automatic t_framer();
      rx_framer_enable_in <= 1'b0;
      repeat (4) idle();
      rxs(K285_RDP, C_K285, 1'b1, 1'b0);
      rx_framer_enable_in <= 1'b1;
      repeat (4) idle();
      rxs(K285_RDN, C_K285, 1'b1, 1'b1);
      idle();
   endtask : t_framer

   ////////////////////////////////////////////////////////////////////////////////
   // clock, sequence and watchdog
   initial begin
      mclk_in = 1'b0;
      forever #5 mclk_in = ~mclk_in;
   end

   initial begin
      rst_in = 1'b1;
      rx_valid_in = 1'b0;
      rx_sym_in = 10'h000;
      rx_framer_enable_in = 1'b1;
      {p_on, trd, l_ch, l_sp, l_rrd} = '0;
      repeat (15) @(posedge mclk_in);
      @(negedge mclk_in);
      t_reset();
      @(posedge mclk_in);
      rst_in <= 1'b0;
      t_fill();
      t_forced();
      t_viol();
      t_eof();
      t_rx();
      t_framer();
      @(negedge mclk_in);
      judge();
      check({9'h000, u_host.alias_cnt == 0}, 10'h001, "alias pairs sent");
      report_and_stop();
   end

   // whole run is well under 200 clocks
   initial begin
      repeat (2000) @(posedge mclk_in);
      failures++;
      report_and_stop();
   end
endmodule : tb
